// ===== hdl/ldtc_regs.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
// Behaviour
// - line-error bits 15-10 set the counting window, code n meaning n+1 clocks, 0 reserved.
// - line-code errors are counted only while the receiver is in steady state.
// - link down is declared when errors in one window reach the bits 9-4 threshold, 0 reserved.
// - descrambler register bits 5-0 set the descrambler error window for link down.
// - diag control bit 14 low listens on the other channel, high on the transmit channel.
// - diag control bit 13 picks transmit channel A (0) or B (1).
// - diag control bit 12 keeps the DC removal module out of reset for a run.
// - averaging depth is two to the power of bits 10-8, code 7 reserved, reset code 4.
// - bits 6-4 select the cable segment, codes 1 to 5, others reserved.
// - the initial-skip count of samples is dropped before the segment starts.
// - a forward shadow of the programmed length after a fault peak is not reported.
module ldtc_regs
   import ldtc_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdata,
   input wire logic steadyState,
   input wire logic lineCodeErr,
   input wire logic descrErr,
   output logic linkDownLine,
   output logic linkDownDescr,
   output logic listenSameChan,
   output logic txChanB,
   output logic keepDcRemovalActive,
   output logic [6:0] avgCycles,
   output logic segValid,
   output logic [2:0] segSelect,
   output logic [2:0] shadowAvgLoc,
   input wire logic tdrStart,
   input wire logic sampleValid,
   input wire logic peakIn,
   output logic tdrBusy,
   output logic sampleKeep,
   output logic peakReport
);

   typedef struct packed {
      logic [15:0] lineCfg;
      logic [15:0] descCfg;
      logic [15:0] diagCtl;
      logic [15:0] diagCtl2;
      logic [15:0] segTiming;
      logic [15:0] shadowCfg;
      logic [15:0] rdata;
      logic [5:0] winCnt;
      logic [5:0] errCnt;
      logic linkDownLine;
      logic [5:0] descCnt;
      logic linkDownDescr;
      logic [6:0] avgCycles;
      logic segValid;
      ldtc_gate_e gate;
      logic [7:0] sampCnt;
      logic [3:0] shadowCnt;
      logic sampleKeep;
      logic peakReport;
      logic tdrBusy;
   } ldtc_state_s;

   ldtc_state_s st;
   ldtc_state_s next_st;

   logic [5:0] winCode;
   logic [5:0] thrCode;
   logic [5:0] descCode;
   logic [6:0] errSum;
   logic [2:0] avgCode;
   logic [2:0] segCode;
   logic [7:0] segDur;
   logic [7:0] initSkip;
   logic [3:0] fwdShadow;

   // field views of the stored registers
   assign winCode = st.lineCfg[LDTC_POS_WIN +: 6];
   assign thrCode = st.lineCfg[LDTC_POS_THR +: 6];
   assign descCode = st.descCfg[LDTC_POS_DTHR +: 6];
   assign segDur = st.segTiming[LDTC_POS_DUR +: 8];
   assign initSkip = st.segTiming[LDTC_POS_SKIP +: 8];
   assign fwdShadow = st.shadowCfg[LDTC_POS_FWD +: 4];
   assign errSum = {1'b0, st.errCnt} + {6'h00, lineCodeErr};

   // next-state logic for bus, link-drop and tdr gate
   always_comb
   begin
      next_st = st;
      next_st.linkDownLine = 1'b0;
      next_st.linkDownDescr = 1'b0;
      next_st.sampleKeep = 1'b0;
      next_st.peakReport = 1'b0;
      next_st.rdata = 16'h0000;

      // register writes, masked so read-only bits stay zero
      if (regWrite)
      begin
         case (regAddr)
            ADDR_W'(LDTC_OFS_LINE_ERR): next_st.lineCfg = regWdata & LDTC_WM_LINE_ERR;
            ADDR_W'(LDTC_OFS_DESCR): next_st.descCfg = regWdata & LDTC_WM_DESCR;
            ADDR_W'(LDTC_OFS_DIAG_CTL): next_st.diagCtl = regWdata & LDTC_WM_DIAG_CTL;
            ADDR_W'(LDTC_OFS_DIAG_CTL2): next_st.diagCtl2 = regWdata & LDTC_WM_DIAG_CTL2;
            ADDR_W'(LDTC_OFS_SEG_TIMING): next_st.segTiming = regWdata & LDTC_WM_SEG_TIMING;
            ADDR_W'(LDTC_OFS_SHADOW): next_st.shadowCfg = regWdata & LDTC_WM_SHADOW;
            default: ;
         endcase
      end

      // read data stands the cycle after the strobe; unmapped reads zero
      if (regRead)
      begin
         case (regAddr)
            ADDR_W'(LDTC_OFS_LINE_ERR): next_st.rdata = st.lineCfg;
            ADDR_W'(LDTC_OFS_DESCR): next_st.rdata = st.descCfg;
            ADDR_W'(LDTC_OFS_DIAG_CTL): next_st.rdata = st.diagCtl;
            ADDR_W'(LDTC_OFS_DIAG_CTL2): next_st.rdata = st.diagCtl2;
            ADDR_W'(LDTC_OFS_SEG_TIMING): next_st.rdata = st.segTiming;
            ADDR_W'(LDTC_OFS_SHADOW): next_st.rdata = st.shadowCfg;
            default: next_st.rdata = 16'h0000;
         endcase
      end

      // decoded tdr settings kept in flops so outputs are registered
      avgCode = next_st.diagCtl[LDTC_POS_AVG +: 3];
      segCode = next_st.diagCtl[LDTC_POS_SEG +: 3];
      if (avgCode == LDTC_AVG_RSVD)
         next_st.avgCycles = LDTC_AVG_MAX; // reserved code clamps to deepest
      else
         next_st.avgCycles = 7'(7'h01 << avgCode);
      next_st.segValid = (segCode >= LDTC_SEG_FIRST) && (segCode <= LDTC_SEG_LAST);

      // line-code error window; reserved codes disable detection
      if (!steadyState || winCode == 6'h00 || thrCode == 6'h00)
      begin
         next_st.winCnt = 6'h00;
         next_st.errCnt = 6'h00;
      end
      else
      begin
         if (errSum >= {1'b0, thrCode})
         begin
            next_st.linkDownLine = 1'b1;
            next_st.errCnt = 6'h00;
         end
         else
            next_st.errCnt = errSum[5:0];
         if (st.winCnt >= winCode)
         begin
            next_st.winCnt = 6'h00;
            next_st.errCnt = 6'h00;
         end
         else
            next_st.winCnt = st.winCnt + 6'h01;
      end

      // descrambler errors: a run of erroring clocks as long as the window
      if (!steadyState || descCode == 6'h00 || !descrErr)
         next_st.descCnt = 6'h00;
      else if (st.descCnt + 6'h01 >= descCode)
      begin
         next_st.descCnt = 6'h00;
         next_st.linkDownDescr = 1'b1;
      end
      else
         next_st.descCnt = st.descCnt + 6'h01;

      // tdr sample gate: skip, then keep a segment's worth of samples
      case (st.gate)
         TG_IDLE:
         begin
            if (tdrStart && st.segValid)
            begin
               next_st.shadowCnt = 4'h0;
               // no skip: the very next sample already belongs to the segment
               if (initSkip == 8'h00)
               begin
                  next_st.gate = TG_SEG;
                  next_st.sampCnt = segDur;
               end
               else
               begin
                  next_st.gate = TG_SKIP;
                  next_st.sampCnt = initSkip;
               end
            end
         end
         TG_SKIP:
         begin
            // switch on the last skipped sample so no extra sample is lost
            if (sampleValid)
            begin
               if (st.sampCnt == 8'h01)
               begin
                  next_st.gate = TG_SEG;
                  next_st.sampCnt = segDur;
               end
               else
                  next_st.sampCnt = st.sampCnt - 8'h01;
            end
         end
         TG_SEG:
         begin
            if (st.sampCnt == 8'h00)
               next_st.gate = TG_IDLE;
            else if (sampleValid)
            begin
               next_st.sampCnt = st.sampCnt - 8'h01;
               next_st.sampleKeep = 1'b1;
               // peaks inside the shadow of the last one are swallowed
               if (peakIn && st.shadowCnt == 4'h0)
               begin
                  next_st.peakReport = 1'b1;
                  next_st.shadowCnt = fwdShadow;
               end
               else if (st.shadowCnt != 4'h0)
                  next_st.shadowCnt = st.shadowCnt - 4'h1;
            end
         end
         default: next_st.gate = TG_IDLE;
      endcase
      next_st.tdrBusy = (next_st.gate != TG_IDLE);
   end

   // single state register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= '0;
         st.lineCfg <= LDTC_RST_LINE_ERR;
         st.descCfg <= LDTC_RST_DESCR;
         st.diagCtl <= LDTC_RST_DIAG_CTL;
         st.diagCtl2 <= LDTC_RST_DIAG_CTL2;
         st.segTiming <= LDTC_RST_SEG_TIMING;
         st.shadowCfg <= LDTC_RST_SHADOW;
         st.avgCycles <= 7'h10;
         st.segValid <= 1'b1;
         st.gate <= TG_IDLE;
      end
      else
         st <= next_st;
   end

   // outputs straight from the state flops
   assign regRdata = st.rdata;
   assign linkDownLine = st.linkDownLine;
   assign linkDownDescr = st.linkDownDescr;
   assign listenSameChan = st.diagCtl[LDTC_POS_SAME];
   assign txChanB = st.diagCtl[LDTC_POS_CHAN];
   assign keepDcRemovalActive = st.diagCtl[LDTC_POS_KEEPDC];
   assign avgCycles = st.avgCycles;
   assign segValid = st.segValid;
   assign segSelect = st.diagCtl[LDTC_POS_SEG +: 3];
   assign shadowAvgLoc = st.shadowCfg[LDTC_POS_SDW +: 3];
   assign tdrBusy = st.tdrBusy;
   assign sampleKeep = st.sampleKeep;
   assign peakReport = st.peakReport;

   // checks on the behaviour above
   a_win_restart: assert property (@(posedge clk) disable iff (!nrst)
      (steadyState && winCode != 6'h00 && thrCode != 6'h00 && st.winCnt >= winCode)
      |=> (st.winCnt == 6'h00 && st.errCnt == 6'h00))
      else $error("window did not restart");

   a_no_count_acq: assert property (@(posedge clk) disable iff (!nrst)
      !steadyState |=> (st.errCnt == 6'h00 && !st.linkDownLine))
      else $error("errors counted outside steady state");

   a_thresh_drop: assert property (@(posedge clk) disable iff (!nrst)
      (steadyState && winCode != 6'h00 && thrCode != 6'h00 && errSum >= {1'b0, thrCode})
      |=> linkDownLine)
      else $error("threshold reached without link down");

   a_drop_cause: assert property (@(posedge clk) disable iff (!nrst)
      linkDownLine |-> $past(steadyState) && $past(thrCode) != 6'h00)
      else $error("link down without cause");

   a_win_bound: assert property (@(posedge clk) disable iff (!nrst)
      (winCode == 6'h00) |=> st.winCnt == 6'h00)
      else $error("window counter out of range");

   a_descr_drop: assert property (@(posedge clk) disable iff (!nrst)
      (steadyState && descCode == 6'h01 && descrErr) |=> linkDownDescr)
      else $error("descrambler threshold missed");

   a_avg_decode: assert property (@(posedge clk) disable iff (!nrst)
      (regWrite && regAddr == ADDR_W'(LDTC_OFS_DIAG_CTL) && regWdata[10:8] == 3'h3)
      |=> avgCycles == 7'h08)
      else $error("averaging depth wrong");

   a_ro_zero: assert property (@(posedge clk) disable iff (!nrst)
      st.lineCfg[3:0] == 4'h0 && !st.diagCtl[15] && st.shadowCfg[15:14] == 2'h0
      && st.shadowCfg[10:5] == 6'h00)
      else $error("read-only bits not zero");

   a_read_next: assert property (@(posedge clk) disable iff (!nrst)
      (regRead && regAddr == ADDR_W'(LDTC_OFS_SHADOW)) |=> regRdata == $past(st.shadowCfg))
      else $error("read data not one cycle later");

   a_shadow_hide: assert property (@(posedge clk) disable iff (!nrst)
      (st.gate == TG_SEG && sampleValid && peakIn && st.shadowCnt != 4'h0 && st.sampCnt != 8'h00)
      |=> !peakReport)
      else $error("peak in shadow reported");

   a_skip_first: assert property (@(posedge clk) disable iff (!nrst)
      (st.gate == TG_SKIP) |=> !sampleKeep)
      else $error("sample kept during skip");

   a_seg_start: assert property (@(posedge clk) disable iff (!nrst)
      (st.gate == TG_IDLE && tdrStart && !st.segValid) |=> !tdrBusy)
      else $error("run started on reserved segment");

   a_chan_map: assert property (@(posedge clk) disable iff (!nrst)
      (regWrite && regAddr == ADDR_W'(LDTC_OFS_DIAG_CTL) && regWdata[14:12] == 3'h2)
      |=> (!listenSameChan && txChanB && !keepDcRemovalActive))
      else $error("channel and dc removal bits not mapped");

   a_seg_select: assert property (@(posedge clk) disable iff (!nrst)
      (regWrite && regAddr == ADDR_W'(LDTC_OFS_DIAG_CTL) && regWdata[6:4] == 3'h5)
      |=> (segSelect == 3'h5 && segValid))
      else $error("segment code not decoded");

   a_busy_start: assert property (@(posedge clk) disable iff (!nrst)
      (st.gate == TG_IDLE && tdrStart && st.segValid) |=> tdrBusy)
      else $error("run on valid segment did not start");

   a_peak_first: assert property (@(posedge clk) disable iff (!nrst)
      (st.gate == TG_SEG && sampleValid && peakIn && st.shadowCnt == 4'h0 && st.sampCnt != 8'h00)
      |=> peakReport)
      else $error("peak outside shadow not reported");

   a_keep_in_seg: assert property (@(posedge clk) disable iff (!nrst)
      sampleKeep |-> $past(st.gate) == TG_SEG)
      else $error("sample kept outside segment");

   a_descr_clean: assert property (@(posedge clk) disable iff (!nrst)
      (steadyState && !descrErr) |=> (st.descCnt == 6'h00 && !linkDownDescr))
      else $error("descrambler run not cleared by clean clock");

endmodule

// ===== hdl/ldtc_pkg.sv
package ldtc_pkg;
   // register offsets, as printed
   localparam logic [11:0] LDTC_OFS_LINE_ERR = 12'h0117;
   localparam logic [11:0] LDTC_OFS_DESCR = 12'h0131;
   localparam logic [11:0] LDTC_OFS_DIAG_CTL = 12'h0170;
   localparam logic [11:0] LDTC_OFS_DIAG_CTL2 = 12'h0171;
   localparam logic [11:0] LDTC_OFS_SEG_TIMING = 12'h0173;
   localparam logic [11:0] LDTC_OFS_SHADOW = 12'h0175;
   // values after reset
   localparam logic [15:0] LDTC_RST_LINE_ERR = 16'h0000;
   localparam logic [15:0] LDTC_RST_DESCR = 16'h0000;
   localparam logic [15:0] LDTC_RST_DIAG_CTL = 16'h0c12;
   localparam logic [15:0] LDTC_RST_DIAG_CTL2 = 16'hc850;
   localparam logic [15:0] LDTC_RST_SEG_TIMING = 16'h0d04;
   localparam logic [15:0] LDTC_RST_SHADOW = 16'h1004;
   // writable bits; read-only bits stay zero
   localparam logic [15:0] LDTC_WM_LINE_ERR = 16'hfff0;
   localparam logic [15:0] LDTC_WM_DESCR = 16'hffff;
   localparam logic [15:0] LDTC_WM_DIAG_CTL = 16'h7fff;
   localparam logic [15:0] LDTC_WM_DIAG_CTL2 = 16'hffff;
   localparam logic [15:0] LDTC_WM_SEG_TIMING = 16'hffff;
   localparam logic [15:0] LDTC_WM_SHADOW = 16'h381f;
   // field positions (low bit)
   localparam int LDTC_POS_WIN = 10;
   localparam int LDTC_POS_THR = 4;
   localparam int LDTC_POS_DTHR = 0;
   localparam int LDTC_POS_SAME = 14;
   localparam int LDTC_POS_CHAN = 13;
   localparam int LDTC_POS_KEEPDC = 12;
   localparam int LDTC_POS_AVG = 8;
   localparam int LDTC_POS_SEG = 4;
   localparam int LDTC_POS_DUR = 8;
   localparam int LDTC_POS_SKIP = 0;
   localparam int LDTC_POS_SDW = 11;
   localparam int LDTC_POS_FWD = 0;
   // codes
   localparam logic [2:0] LDTC_AVG_RSVD = 3'h7;
   localparam logic [2:0] LDTC_SEG_FIRST = 3'h1;
   localparam logic [2:0] LDTC_SEG_LAST = 3'h5;
   localparam logic [6:0] LDTC_AVG_MAX = 7'h40;

   typedef enum logic [1:0] {TG_IDLE, TG_SKIP, TG_SEG} ldtc_gate_e;
endpackage

// ===== verif/ldtc_regs_tb_top.sv
`timescale 1ns/1ns
module ldtc_regs_tb_top import ldtc_pkg::*;;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [15:0] regWdata = 16'h0000;
   logic regWrite = 1'b0, regRead = 1'b0, steadyState = 1'b0, lineCodeErr = 1'b0;
   logic descrErr = 1'b0, tdrStart = 1'b0, sampleValid = 1'b0, peakIn = 1'b0;
   logic [15:0] regRdata;
   logic linkDownLine, linkDownDescr, listenSameChan, txChanB, keepDcRemovalActive;
   logic segValid, tdrBusy, sampleKeep, peakReport;
   logic [6:0] avgCycles;
   logic [2:0] segSelect, shadowAvgLoc;
   int numErrors = 0, checkCount = 0, nLine = 0, nDescr = 0, nKeep = 0, nRep = 0;
   logic [11:0] ofs [6] = '{LDTC_OFS_LINE_ERR, LDTC_OFS_DESCR, LDTC_OFS_DIAG_CTL,
      LDTC_OFS_DIAG_CTL2, LDTC_OFS_SEG_TIMING, LDTC_OFS_SHADOW};
   logic [15:0] rstv [6] = '{LDTC_RST_LINE_ERR, LDTC_RST_DESCR, LDTC_RST_DIAG_CTL,
      LDTC_RST_DIAG_CTL2, LDTC_RST_SEG_TIMING, LDTC_RST_SHADOW};
   logic [15:0] wmv [6] = '{LDTC_WM_LINE_ERR, LDTC_WM_DESCR, LDTC_WM_DIAG_CTL,
      LDTC_WM_DIAG_CTL2, LDTC_WM_SEG_TIMING, LDTC_WM_SHADOW};

   ldtc_regs i_ldtc_regs (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .steadyState(steadyState), .lineCodeErr(lineCodeErr), .descrErr(descrErr),
      .linkDownLine(linkDownLine), .linkDownDescr(linkDownDescr),
      .listenSameChan(listenSameChan), .txChanB(txChanB),
      .keepDcRemovalActive(keepDcRemovalActive), .avgCycles(avgCycles),
      .segValid(segValid), .segSelect(segSelect), .shadowAvgLoc(shadowAvgLoc),
      .tdrStart(tdrStart), .sampleValid(sampleValid), .peakIn(peakIn), .tdrBusy(tdrBusy),
      .sampleKeep(sampleKeep), .peakReport(peakReport));

   // 100 MHz clock
   always #5 clk = ~clk;

   // pulse counters; one-cycle pulses would be missed by polling
   always @(posedge clk)
   begin
      if (linkDownLine === 1'b1) nLine++;
      if (linkDownDescr === 1'b1) nDescr++;
      if (sampleKeep === 1'b1) nKeep++;
      if (peakReport === 1'b1) nRep++;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic endSim;
      $display("checks %0d, mismatches %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   // data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      d = regRdata;
   endtask

   // two errors gap clocks apart; steadyState and the first error start together
   task automatic lineRun(input logic [15:0] cfg, input int gap, input logic st, input int n);
      int base;
      wr(LDTC_OFS_LINE_ERR, cfg);
      base = nLine;
      @(posedge clk);
      steadyState <= st;
      lineCodeErr <= 1'b1;
      @(posedge clk);
      if (gap > 1)
      begin
         lineCodeErr <= 1'b0;
         repeat (gap - 1) @(posedge clk);
         lineCodeErr <= 1'b1;
      end
      @(posedge clk);
      lineCodeErr <= 1'b0;
      repeat (4) @(posedge clk);
      steadyState <= 1'b0;
      #1;
      chk(16'(nLine - base), 16'(n));
   endtask

   // every sample valid and peaked; shadow length decides how many peaks survive
   task automatic tdrRun(input logic [15:0] ctl, input logic [15:0] shd, input int k, input int r);
      int keep0;
      int rep0;
      wr(LDTC_OFS_DIAG_CTL, ctl);
      wr(LDTC_OFS_SHADOW, shd);
      keep0 = nKeep;
      rep0 = nRep;
      @(posedge clk);
      tdrStart <= 1'b1;
      @(posedge clk);
      tdrStart <= 1'b0;
      sampleValid <= 1'b1;
      peakIn <= 1'b1;
      repeat (12) @(posedge clk);
      sampleValid <= 1'b0;
      peakIn <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(16'(nKeep - keep0), 16'(k));
      chk(16'(nRep - rep0), 16'(r));
      chk({15'h0, tdrBusy}, 16'h0000);
   endtask

   initial
   begin
      logic [15:0] v;
      int d0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk({9'h0, avgCycles}, 16'h0010);
      chk({13'h0, segSelect}, 16'h0001);
      chk({13'h0, shadowAvgLoc}, 16'h0002);
      // reset values, writable masks, read data dropping back to zero
      for (int i = 0; i < 6; i++)
      begin
         rd(ofs[i], v);
         chk(v, rstv[i]);
         wr(ofs[i], 16'hffff);
         rd(ofs[i], v);
         chk(v, wmv[i]);
         @(posedge clk);
         #1;
         chk(regRdata, 16'h0000);
         wr(ofs[i], rstv[i]);
      end
      wr(12'h172, 16'hffff);
      rd(12'h172, v);
      chk(v, 16'h0000);
      wr(LDTC_OFS_DIAG_CTL, 16'h7000);
      @(posedge clk);
      #1;
      chk({13'h0, listenSameChan, txChanB, keepDcRemovalActive}, 16'h0007);
      wr(LDTC_OFS_DIAG_CTL, 16'h2000);
      @(posedge clk);
      #1;
      chk({13'h0, listenSameChan, txChanB, keepDcRemovalActive}, 16'h0002);
      // every averaging and segment code, reserved ones included
      for (int c = 0; c < 8; c++)
      begin
         wr(LDTC_OFS_DIAG_CTL, 16'((c << 8) | (c << 4)));
         @(posedge clk);
         #1;
         chk({9'h0, avgCycles}, (c == 7) ? 16'h0040 : 16'(1 << c));
         chk({12'h0, segValid, segSelect}, {12'h0, c >= 1 && c <= 5, 3'(c)});
      end
      lineRun(16'h0420, 1, 1'b1, 1);
      lineRun(16'h0420, 2, 1'b1, 0);
      lineRun(16'h0430, 1, 1'b1, 0);
      lineRun(16'hfc20, 63, 1'b1, 1);
      lineRun(16'hfc20, 64, 1'b1, 0);
      lineRun(16'h0420, 1, 1'b0, 0);
      lineRun(16'h0020, 1, 1'b1, 0);
      // descrambler: a run of two, a clean clock, then a run of three
      wr(LDTC_OFS_DESCR, 16'h0003);
      d0 = nDescr;
      @(posedge clk);
      steadyState <= 1'b1;
      descrErr <= 1'b1;
      repeat (2) @(posedge clk);
      descrErr <= 1'b0;
      @(posedge clk);
      descrErr <= 1'b1;
      repeat (3) @(posedge clk);
      descrErr <= 1'b0;
      repeat (4) @(posedge clk);
      steadyState <= 1'b0;
      #1;
      chk(16'(nDescr - d0), 16'h0001);
      // code 1: every erroring clock declares link down on its own
      wr(LDTC_OFS_DESCR, 16'h0001);
      d0 = nDescr;
      @(posedge clk);
      steadyState <= 1'b1;
      descrErr <= 1'b1;
      repeat (2) @(posedge clk);
      descrErr <= 1'b0;
      repeat (4) @(posedge clk);
      steadyState <= 1'b0;
      #1;
      chk(16'(nDescr - d0), 16'h0002);
      // recommended first-segment timing, then a short one to keep runs brief
      wr(LDTC_OFS_SEG_TIMING, 16'h0d07);
      rd(LDTC_OFS_SEG_TIMING, v);
      chk(v, 16'h0d07);
      wr(LDTC_OFS_SEG_TIMING, 16'h0302);
      tdrRun(16'h0c12, 16'h1000, 3, 3);
      tdrRun(16'h0c12, 16'h1001, 3, 2);
      tdrRun(16'h0c02, 16'h1001, 0, 0);
      endSim();
   end

   // watchdog: the whole sequence needs a few hundred clocks
   initial
   begin
      repeat (20000) @(posedge clk);
      numErrors++;
      endSim();
   end
endmodule
